/* File: hw/refbuf_pkg.sv */
package refbuf_pkg;

  localparam int          SLOTS      = 8;
  localparam int          SUBPICS    = 8;
  localparam int          IDX_W      = 4;
  localparam int          SLOT_W     = 3;

  // Register byte offsets.
  localparam logic [7:0]  PIC_OFS    = 8'h00;
  localparam logic [7:0]  CMD_OFS    = 8'h04;
  localparam logic [7:0]  CAP_OFS    = 8'h08;
  localparam logic [7:0]  STAT_OFS   = 8'h0C;
  localparam logic [7:0]  IRQS_OFS   = 8'h10;
  localparam logic [7:0]  IRQC_OFS   = 8'h14;
  localparam logic [7:0]  IRQE_OFS   = 8'h18;
  localparam logic [7:0]  SEL_OFS    = 8'h1C;
  localparam logic [7:0]  INFO_OFS   = 8'h20;

  // Picture word fields.
  localparam int          PIC_BIDIR  = 0;
  localparam int          PIC_ADAPT  = 1;
  localparam int          PIC_NEED   = 8;

  // Command word fields.
  localparam int          CMD_OP     = 0;
  localparam int          CMD_DEF    = 8;
  localparam int          CMD_LT     = 16;
  localparam int          CMD_MASK   = 24;

  // Interrupt bit positions.
  localparam int          EV_DONE    = 0;
  localparam int          EV_ERR     = 1;
  localparam int          EV_REFUSE  = 2;

  localparam logic [7:0]  CAP_RESET  = 8'h40;
  localparam logic [1:0]  RESP_OKAY  = 2'h0;
  localparam logic [1:0]  RESP_DEC   = 2'h3;

  typedef enum logic [2:0] {
    CMD_END    = 3'h0,
    CMD_RESET  = 3'h1,
    CMD_MAXLT  = 3'h2,
    CMD_UNUSE  = 3'h3,
    CMD_SUBPIC = 3'h4,
    CMD_ASSIGN = 3'h5
  } cmd_type;

  typedef enum logic [2:0] {
    S_IDLE   = 3'h0,
    S_EVICT  = 3'h1,
    S_INSERT = 3'h2,
    S_OPEN   = 3'h3,
    S_CHECK  = 3'h4
  } fsm_type;

  typedef struct packed {
    logic               used;
    logic               lterm;
    logic [IDX_W-1:0]   lt_idx;
    logic [IDX_W-1:0]   def_idx;
    logic [SUBPICS-1:0] sub_mask;
  } slot_type;

endpackage : refbuf_pkg

/* File: hw/refbuf_mgr.sv */
`timescale 1ns/1ps
module refbuf_mgr (
  // Clock and reset.
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // AXI4-Lite write channels.
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // AXI4-Lite read channels.
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // Interrupt.
  output logic             irq
);

  localparam int S = refbuf_pkg::SLOTS;

  typedef struct packed {
    refbuf_pkg::fsm_type                   st;
    refbuf_pkg::slot_type [S-1:0]          slot;
    logic [7:0]                            cap;
    logic [refbuf_pkg::SLOT_W-1:0]         sel;
    logic                                  adaptive;
    logic [refbuf_pkg::IDX_W-1:0]          need;
    logic [refbuf_pkg::IDX_W-1:0]          evicted;
    logic [refbuf_pkg::SLOT_W-1:0]         cur;
    logic [2:0]                            irq_stat;
    logic [2:0]                            irq_en;
    logic                                  irq;
    logic                                  aw_got;
    logic                                  w_got;
    logic [7:0]                            awaddr;
    logic [31:0]                           wdata;
    logic                                  awready;
    logic                                  wready;
    logic                                  bvalid;
    logic [1:0]                            bresp;
    logic                                  arready;
    logic                                  rvalid;
    logic [1:0]                            rresp;
    logic [31:0]                           rdata;
  } state_type;

  state_type                     s_reg;
  state_type                     s_next;
  logic [7:0]                    occ;
  logic                          have_free;
  logic [refbuf_pkg::SLOT_W-1:0] free_i;
  logic                          has_st;
  logic [refbuf_pkg::SLOT_W-1:0] old_i;
  logic                          wr_go;
  logic                          pic_go;
  logic                          cmd_go;
  logic [31:0]                   wd;
  logic                          tgt_ok;
  logic [refbuf_pkg::SLOT_W-1:0] tgt_i;
  logic [2:0]                    ev;
  logic [2:0]                    clr;
  logic [refbuf_pkg::IDX_W-1:0]  hi;
  logic                          any_dec;
  logic [7:0]                    wa;

  ////////////////////////////////////////////////////////////////////////////

  // Every retained area is charged a whole sub-picture, so edge areas count
  // in full and memory never fragments.
  function automatic logic [7:0] occupancy(input refbuf_pkg::slot_type [S-1:0] sl);
    logic [7:0] sum;
    sum = 8'h00;
    for (int i = 0; i < S; i++) begin
      for (int b = 0; b < refbuf_pkg::SUBPICS; b++) begin
        sum = sum + 8'(sl[i].used & sl[i].sub_mask[b]);
      end
    end
    return sum;
  endfunction : occupancy

  ////////////////////////////////////////////////////////////////////////////

  always_comb begin
    s_next  = s_reg;
    ev      = 3'h0;
    clr     = 3'h0;
    hi      = '0;
    any_dec = 1'b0;
    occ     = occupancy(s_reg.slot);
    have_free = 1'b0;
    free_i    = '0;
    has_st    = 1'b0;
    old_i     = '0;
    for (int i = S - 1; i >= 0; i--) begin
      if (!s_reg.slot[i].used) begin
        have_free = 1'b1;
        free_i    = refbuf_pkg::SLOT_W'(i);
      end
    end
    for (int i = 0; i < S; i++) begin
      if (s_reg.slot[i].used && !s_reg.slot[i].lterm &&
          (!has_st || s_reg.slot[i].def_idx > s_reg.slot[old_i].def_idx)) begin
        has_st = 1'b1;
        old_i  = refbuf_pkg::SLOT_W'(i);
      end
    end

    // Bus write side: address and data are taken in either order.
    if (s_axi_awvalid && s_reg.awready) begin
      s_next.aw_got = 1'b1;
      s_next.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_reg.wready) begin
      s_next.w_got = 1'b1;
      s_next.wdata = s_axi_wdata & {{8{s_axi_wstrb[3]}}, {8{s_axi_wstrb[2]}},
                                    {8{s_axi_wstrb[1]}}, {8{s_axi_wstrb[0]}}};
    end
    if (s_reg.bvalid && s_axi_bready) begin
      s_next.bvalid = 1'b0;
    end
    wr_go = s_next.aw_got && s_next.w_got && !s_reg.bvalid;
    wd    = s_next.wdata;
    wa    = s_next.awaddr;
    if (wr_go) begin
      s_next.aw_got = 1'b0;
      s_next.w_got  = 1'b0;
      s_next.bvalid = 1'b1;
      s_next.bresp  = (wa > refbuf_pkg::INFO_OFS || wa[1:0] != 2'h0) ?
                      refbuf_pkg::RESP_DEC : refbuf_pkg::RESP_OKAY;
      case (wa)
        refbuf_pkg::CAP_OFS: begin
          s_next.cap = wd[7:0];
        end
        refbuf_pkg::IRQC_OFS: begin
          clr = wd[2:0];
        end
        refbuf_pkg::IRQE_OFS: begin
          s_next.irq_en = wd[2:0];
        end
        refbuf_pkg::SEL_OFS: begin
          s_next.sel = wd[refbuf_pkg::SLOT_W-1:0];
        end
        default: begin
        end
      endcase
    end

    // A picture is only taken when the previous one is fully retired.
    pic_go = wr_go && wa == refbuf_pkg::PIC_OFS && s_reg.st == refbuf_pkg::S_IDLE;
    cmd_go = wr_go && wa == refbuf_pkg::CMD_OFS && s_reg.st == refbuf_pkg::S_OPEN;
    if (wr_go && !pic_go && !cmd_go &&
        (wa == refbuf_pkg::PIC_OFS || wa == refbuf_pkg::CMD_OFS)) begin
      ev[refbuf_pkg::EV_REFUSE] = 1'b1;
    end

    tgt_ok = 1'b0;
    tgt_i  = '0;
    for (int i = 0; i < S; i++) begin
      if (s_reg.slot[i].used &&
          s_reg.slot[i].def_idx == wd[refbuf_pkg::CMD_DEF +: refbuf_pkg::IDX_W]) begin
        tgt_ok = 1'b1;
        tgt_i  = refbuf_pkg::SLOT_W'(i);
      end
    end

    case (s_reg.st)
      refbuf_pkg::S_IDLE: begin
        if (pic_go) begin
          s_next.need     = wd[refbuf_pkg::PIC_NEED +: refbuf_pkg::IDX_W];
          s_next.adaptive = wd[refbuf_pkg::PIC_ADAPT];
          s_next.evicted  = '0;
          if (wd[refbuf_pkg::PIC_BIDIR]) begin
            ev[refbuf_pkg::EV_DONE] = 1'b1;
          end else if (wd[refbuf_pkg::PIC_ADAPT]) begin
            s_next.st = refbuf_pkg::S_INSERT;
          end else begin
            s_next.st = refbuf_pkg::S_EVICT;
          end
        end
      end
      refbuf_pkg::S_EVICT: begin
        // One eviction per cycle keeps the search logic to a single pass.
        if (have_free && s_reg.cap >= occ &&
            8'(s_reg.cap - occ) >= 8'(s_reg.need)) begin
          s_next.st = refbuf_pkg::S_INSERT;
        end else if (has_st) begin
          s_next.slot[old_i].used = 1'b0;
          s_next.evicted = s_reg.evicted + 1'b1;
        end else begin
          ev[refbuf_pkg::EV_ERR] = 1'b1;
          s_next.st = refbuf_pkg::S_INSERT;
        end
      end
      refbuf_pkg::S_INSERT: begin
        if (!have_free) begin
          ev[refbuf_pkg::EV_ERR]  = 1'b1;
          ev[refbuf_pkg::EV_DONE] = 1'b1;
          s_next.st = refbuf_pkg::S_IDLE;
        end else begin
          for (int i = 0; i < S; i++) begin
            if (s_reg.slot[i].used) begin
              if (s_reg.adaptive || !s_reg.slot[i].lterm) begin
                s_next.slot[i].def_idx = s_reg.slot[i].def_idx + 1'b1;
              end else begin
                s_next.slot[i].def_idx = s_reg.slot[i].def_idx + 1'b1 - s_reg.evicted;
              end
            end
          end
          s_next.slot[free_i].used     = 1'b1;
          s_next.slot[free_i].lterm    = 1'b0;
          s_next.slot[free_i].lt_idx   = '0;
          s_next.slot[free_i].def_idx  = '0;
          s_next.slot[free_i].sub_mask = 8'hFF >> (4'd8 - s_reg.need);
          s_next.cur = free_i;
          s_next.st  = s_reg.adaptive ? refbuf_pkg::S_OPEN : refbuf_pkg::S_CHECK;
        end
      end
      refbuf_pkg::S_OPEN: begin
        // Commands run one per bus write, in arrival order.
        if (cmd_go) begin
          case (refbuf_pkg::cmd_type'(wd[refbuf_pkg::CMD_OP +: 3]))
            refbuf_pkg::CMD_END: begin
              s_next.st = refbuf_pkg::S_CHECK;
            end
            refbuf_pkg::CMD_RESET: begin
              // Relies on the parser sending reset first, when current is index 0.
              for (int i = 0; i < S; i++) begin
                if (refbuf_pkg::SLOT_W'(i) != s_reg.cur) begin
                  s_next.slot[i].used = 1'b0;
                end
              end
            end
            refbuf_pkg::CMD_MAXLT: begin
              for (int i = 0; i < S; i++) begin
                if (s_reg.slot[i].lterm &&
                    s_reg.slot[i].lt_idx >= wd[refbuf_pkg::CMD_LT +: refbuf_pkg::IDX_W]) begin
                  s_next.slot[i].used = 1'b0;
                end
              end
            end
            refbuf_pkg::CMD_UNUSE: begin
              if (!tgt_ok) begin
                ev[refbuf_pkg::EV_REFUSE] = 1'b1;
              end else begin
                s_next.slot[tgt_i].used = 1'b0;
                for (int i = 0; i < S; i++) begin
                  if (s_reg.slot[i].used &&
                      s_reg.slot[i].def_idx > s_reg.slot[tgt_i].def_idx) begin
                    s_next.slot[i].def_idx = s_reg.slot[i].def_idx - 1'b1;
                  end
                end
              end
            end
            refbuf_pkg::CMD_SUBPIC: begin
              // Clearing every area is the parser's fault and is not trapped.
              if (!tgt_ok) begin
                ev[refbuf_pkg::EV_REFUSE] = 1'b1;
              end else begin
                s_next.slot[tgt_i].sub_mask = s_reg.slot[tgt_i].sub_mask &
                                              ~wd[refbuf_pkg::CMD_MASK +: 8];
              end
            end
            refbuf_pkg::CMD_ASSIGN: begin
              if (!tgt_ok || (s_reg.slot[tgt_i].lterm &&
                  s_reg.slot[tgt_i].lt_idx != wd[refbuf_pkg::CMD_LT +: refbuf_pkg::IDX_W])) begin
                ev[refbuf_pkg::EV_REFUSE] = 1'b1;
              end else if (!s_reg.slot[tgt_i].lterm) begin
                for (int i = 0; i < S; i++) begin
                  if (s_reg.slot[i].used && s_reg.slot[i].lterm &&
                      s_reg.slot[i].lt_idx == wd[refbuf_pkg::CMD_LT +: refbuf_pkg::IDX_W]) begin
                    s_next.slot[i].used = 1'b0;
                  end else if (s_reg.slot[i].used &&
                      ((!s_reg.slot[i].lterm &&
                        s_reg.slot[i].def_idx > s_reg.slot[tgt_i].def_idx) ||
                       (s_reg.slot[i].lterm && s_reg.slot[i].lt_idx <
                        wd[refbuf_pkg::CMD_LT +: refbuf_pkg::IDX_W]))) begin
                    s_next.slot[i].def_idx = s_reg.slot[i].def_idx - 1'b1;
                    if (!any_dec || s_next.slot[i].def_idx > hi) begin
                      hi = s_next.slot[i].def_idx;
                    end
                    any_dec = 1'b1;
                  end
                end
                s_next.slot[tgt_i].lterm   = 1'b1;
                s_next.slot[tgt_i].lt_idx  = wd[refbuf_pkg::CMD_LT +: refbuf_pkg::IDX_W];
                s_next.slot[tgt_i].def_idx = any_dec ? hi + 1'b1 : '0;
              end
            end
            default: begin
              ev[refbuf_pkg::EV_REFUSE] = 1'b1;
            end
          endcase
        end
      end
      refbuf_pkg::S_CHECK: begin
        if (occ > s_reg.cap) begin
          ev[refbuf_pkg::EV_ERR] = 1'b1;
        end
        ev[refbuf_pkg::EV_DONE] = 1'b1;
        s_next.st = refbuf_pkg::S_IDLE;
      end
      default: begin
        s_next.st = refbuf_pkg::S_IDLE;
      end
    endcase

    // A new event wins over a clear in the same cycle.
    s_next.irq_stat = (s_reg.irq_stat & ~clr) | ev;
    s_next.irq      = |(s_next.irq_stat & s_next.irq_en);

    // Bus read side: answered one cycle after the address is taken.
    if (s_reg.rvalid && s_axi_rready) begin
      s_next.rvalid = 1'b0;
    end
    if (s_axi_arvalid && s_reg.arready) begin
      s_next.rvalid = 1'b1;
      s_next.rresp  = refbuf_pkg::RESP_OKAY;
      case (s_axi_araddr)
        refbuf_pkg::CAP_OFS:  s_next.rdata = {24'h000000, s_reg.cap};
        refbuf_pkg::STAT_OFS: s_next.rdata = {13'h0000, s_reg.cur, 5'h00, s_reg.st, occ};
        refbuf_pkg::IRQS_OFS: s_next.rdata = {29'h00000000, s_reg.irq_stat};
        refbuf_pkg::IRQE_OFS: s_next.rdata = {29'h00000000, s_reg.irq_en};
        refbuf_pkg::SEL_OFS:  s_next.rdata = {29'h00000000, s_reg.sel};
        refbuf_pkg::INFO_OFS: s_next.rdata = {14'h0000, s_reg.slot[s_reg.sel]};
        refbuf_pkg::PIC_OFS,
        refbuf_pkg::CMD_OFS,
        refbuf_pkg::IRQC_OFS: s_next.rdata = 32'h00000000;
        default: begin
          s_next.rdata = 32'h00000000;
          s_next.rresp = refbuf_pkg::RESP_DEC;
        end
      endcase
    end
    s_next.arready = !s_next.rvalid;
    s_next.awready = !s_next.aw_got && !s_next.bvalid;
    s_next.wready  = !s_next.w_got && !s_next.bvalid;
  end

  ////////////////////////////////////////////////////////////////////////////

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_reg     <= '0;
      s_reg.st  <= refbuf_pkg::S_IDLE;
      s_reg.cap <= refbuf_pkg::CAP_RESET;
    end else begin
      s_reg <= s_next;
    end
  end

  assign s_axi_awready = s_reg.awready;
  assign s_axi_wready  = s_reg.wready;
  assign s_axi_bvalid  = s_reg.bvalid;
  assign s_axi_bresp   = s_reg.bresp;
  assign s_axi_arready = s_reg.arready;
  assign s_axi_rvalid  = s_reg.rvalid;
  assign s_axi_rresp   = s_reg.rresp;
  assign s_axi_rdata   = s_reg.rdata;
  assign irq           = s_reg.irq;

  ////////////////////////////////////////////////////////////////////////////

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence seq_slide_pic;
    pic_go && !wd[refbuf_pkg::PIC_BIDIR] && !wd[refbuf_pkg::PIC_ADAPT];
  endsequence

  sequence seq_slide_done;
    s_reg.st == refbuf_pkg::S_EVICT ##1 s_reg.st != refbuf_pkg::S_IDLE;
  endsequence

  a_bidir_keep: assert property (pic_go && wd[refbuf_pkg::PIC_BIDIR] |=>
    s_reg.slot == $past(s_reg.slot) && s_reg.st == refbuf_pkg::S_IDLE)
    else $error("Bidirectional picture changed the buffer.");
  a_mode_slide: assert property (seq_slide_pic |=> seq_slide_done)
    else $error("Sliding picture did not enter eviction.");
  a_evict_oldest: assert property (s_reg.st == refbuf_pkg::S_EVICT && has_st &&
    !(have_free && s_reg.cap >= occ && 8'(s_reg.cap - occ) >= 8'(s_reg.need))
    |=> !s_reg.slot[$past(old_i)].used)
    else $error("Oldest short-term picture was not evicted.");
  a_insert_zero: assert property (s_reg.st == refbuf_pkg::S_INSERT && have_free |=>
    s_reg.slot[s_reg.cur].used && s_reg.slot[s_reg.cur].def_idx == '0 &&
    !s_reg.slot[s_reg.cur].lterm)
    else $error("Current picture not stored at index zero.");
  a_reset_only: assert property (cmd_go &&
    wd[refbuf_pkg::CMD_OP +: 3] == refbuf_pkg::CMD_RESET |=>
    $countones({s_reg.slot[0].used, s_reg.slot[1].used, s_reg.slot[2].used,
                s_reg.slot[3].used, s_reg.slot[4].used, s_reg.slot[5].used,
                s_reg.slot[6].used, s_reg.slot[7].used}) <= 1)
    else $error("Buffer reset left other pictures in use.");
  a_unuse_target: assert property (cmd_go && tgt_ok &&
    wd[refbuf_pkg::CMD_OP +: 3] == refbuf_pkg::CMD_UNUSE |=> !s_reg.slot[$past(tgt_i)].used)
    else $error("Named picture still in use.");
  a_assign_long: assert property (cmd_go && tgt_ok && !s_reg.slot[tgt_i].lterm &&
    wd[refbuf_pkg::CMD_OP +: 3] == refbuf_pkg::CMD_ASSIGN |=>
    s_reg.slot[$past(tgt_i)].lterm &&
    s_reg.slot[$past(tgt_i)].lt_idx == $past(wd[refbuf_pkg::CMD_LT +: refbuf_pkg::IDX_W]))
    else $error("Long-term assignment not applied.");
  a_cap_error: assert property (s_reg.st == refbuf_pkg::S_CHECK && occ > s_reg.cap |=>
    s_reg.irq_stat[refbuf_pkg::EV_ERR])
    else $error("Capacity overflow not flagged.");
  a_one_pic: assert property (s_reg.st == refbuf_pkg::S_OPEN && !cmd_go |=>
    s_reg.st == refbuf_pkg::S_OPEN)
    else $error("Picture closed without an end command.");

endmodule : refbuf_mgr

/* File: bench/refbuf_host.sv */
`timescale 1ns/1ps
// Command source model: a bus master that hands over pictures and commands in order.
// It waits for each answer, puts any buffer reset first and never clears every
// sub-picture area of a picture.
module refbuf_host (
  // Clock.
  input  wire logic        aclk,
  // Write channels.
  output logic [7:0]       s_axi_awaddr,
  output logic             s_axi_awvalid,
  input  wire logic        s_axi_awready,
  output logic [31:0]      s_axi_wdata,
  output logic             s_axi_wvalid,
  input  wire logic        s_axi_wready,
  output logic             s_axi_bready,
  input  wire logic        s_axi_bvalid,
  // Read channels.
  output logic [7:0]       s_axi_araddr,
  output logic             s_axi_arvalid,
  input  wire logic        s_axi_arready,
  output logic             s_axi_rready,
  input  wire logic        s_axi_rvalid,
  input  wire logic [31:0] s_axi_rdata
);
  initial begin
    {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
  end
  // Released lines show the inverse of their last value, so a late sample never matches.
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    forever begin
      @(posedge aclk);
      if (s_axi_bvalid) break;
      if (s_axi_awvalid && s_axi_awready) begin
        s_axi_awvalid <= 1'b0;
        s_axi_awaddr  <= ~a;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        s_axi_wvalid <= 1'b0;
        s_axi_wdata  <= ~d;
      end
    end
    s_axi_bready <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge aclk);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    forever begin
      @(posedge aclk);
      if (s_axi_rvalid) break;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arvalid <= 1'b0;
        s_axi_araddr  <= ~a;
      end
    end
    d = s_axi_rdata;
    s_axi_rready <= 1'b0;
  endtask : rd
endmodule : refbuf_host

/* File: bench/test_reference_picture_buffer_manager.sv */
`timescale 1ns/1ps
module test_reference_picture_buffer_manager;
  typedef struct {logic [31:0] v; logic [31:0] m; logic [1:0] r;} note_type;
  logic        aclk = 1'b0, aresetn = 1'b0, irq;
  logic [7:0]  s_axi_awaddr, s_axi_araddr, c;
  logic [31:0] s_axi_wdata, s_axi_rdata, d;
  logic [3:0]  s_axi_wstrb = 4'hF;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [2:0]  s0, s1, s2, s3, t;
  int          bad_count = 0, comparisons = 0;
  note_type    q[$];
  logic [1:0]  bq[$];
  always #2 aclk = ~aclk;
  refbuf_mgr i_refbuf_mgr (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .irq);
  refbuf_host i_refbuf_host (.aclk, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wvalid, .s_axi_wready, .s_axi_bready, .s_axi_bvalid,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rready, .s_axi_rvalid, .s_axi_rdata);
  ////////////////////////////////////////////////////////////////////////////////
  task automatic mis(input string s);
    bad_count++;
    $display("MISMATCH at %0t: %s", $time, s);
  endtask : mis
  task automatic cmp_rd(input note_type n);
    comparisons++;
    if (((s_axi_rdata & n.m) !== (n.v & n.m)) || (s_axi_rresp !== n.r)) mis("read word");
  endtask : cmp_rd
  task automatic cmp_irq(input logic e);
    comparisons++;
    if (irq !== e) mis("interrupt level");
  endtask : cmp_irq
  task automatic cmp_wr(input logic [1:0] r);
    comparisons++;
    if (s_axi_bresp !== r) mis("write response");
  endtask : cmp_wr
  always @(posedge aclk) if (s_axi_rvalid && s_axi_rready) cmp_rd(q.pop_front());
  always @(posedge aclk) if (s_axi_bvalid && s_axi_bready) cmp_wr(bq.pop_front());
  task automatic rd(input logic [7:0] a, input logic [31:0] v, input logic [31:0] m,
                    input logic [1:0] r = refbuf_pkg::RESP_OKAY);
    q.push_back('{v, m, r});
    i_refbuf_host.rd(a, d);
  endtask : rd
  task automatic wr(input logic [7:0] a, input logic [31:0] w,
                    input logic [1:0] r = refbuf_pkg::RESP_OKAY);
    bq.push_back(r);
    i_refbuf_host.wr(a, w);
  endtask : wr
  task automatic cmd(input logic [31:0] w);
    wr(refbuf_pkg::CMD_OFS, w);
  endtask : cmd
  task automatic info(input logic [2:0] s, input logic [31:0] v, input logic [31:0] m);
    wr(refbuf_pkg::SEL_OFS, {29'h0, s});
    rd(refbuf_pkg::INFO_OFS, v, m);
  endtask : info
  // Polling with a zero mask keeps the note queue in step with every read.
  task automatic settle;
    do rd(refbuf_pkg::STAT_OFS, 32'h0, 32'h0); while (d[10:8] != 3'h0 && d[10:8] != 3'h3);
  endtask : settle
  task automatic pic(input logic [31:0] w, output logic [2:0] s);
    wr(refbuf_pkg::PIC_OFS, w);
    settle();
    s = d[18:16];
  endtask : pic
  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : end_of_test
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    #40000;
    mis("watchdog expired");
    end_of_test();
  end
  initial begin
    c = 8'h10 | 8'($urandom(96));
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    rd(refbuf_pkg::CAP_OFS, 32'h40, 32'hFF);
    cmp_irq(1'b0);
    wr(refbuf_pkg::CAP_OFS, {24'h0, c});
    rd(refbuf_pkg::CAP_OFS, {24'h0, c}, 32'hFF);
    wr(refbuf_pkg::IRQE_OFS, 32'h7);
    pic(32'h100, s0);
    pic(32'h100, s1);
    pic(32'h100, s2);
    info(s0, 32'h0002_0200, 32'h0003_0F00);
    info(s2, 32'h0002_0000, 32'h0003_0F00);
    cmp_irq(1'b1);
    wr(refbuf_pkg::IRQC_OFS, 32'h7);
    pic(32'h001, t);
    info(s0, 32'h0002_0200, 32'h0003_0F00);
    rd(refbuf_pkg::STAT_OFS, 32'h3, 32'hFF);
    $display("sliding window test done");
    pic(32'h102, s3);
    info(s0, 32'h0002_0300, 32'h0003_0F00);
    info(s3, 32'h0002_0000, 32'h0003_0F00);
    cmd(32'h0000_0103);
    info(s2, 32'h0, 32'h0002_0000);
    info(s0, 32'h0002_0200, 32'h0003_0F00);
    cmd(32'h0005_0005);
    info(s3, 32'h0003_5200, 32'h0003_FF00);
    info(s0, 32'h0002_0100, 32'h0003_0F00);
    cmd(32'h0005_0105);
    info(s3, 32'h0, 32'h0002_0000);
    cmd(32'h0005_0002);
    info(s0, 32'h0, 32'h0002_0000);
    cmd(32'h0);
    settle();
    rd(refbuf_pkg::IRQS_OFS, 32'h1, 32'h7);
    $display("adaptive control test done");
    wr(refbuf_pkg::IRQC_OFS, 32'h7);
    cmd(32'h0);
    rd(refbuf_pkg::IRQS_OFS, 32'h4, 32'h7);
    cmp_irq(1'b1);
    wr(refbuf_pkg::IRQE_OFS, 32'h3);
    rd(refbuf_pkg::IRQS_OFS, 32'h4, 32'h7);
    cmp_irq(1'b0);
    wr(refbuf_pkg::IRQC_OFS, 32'h7);
    $display("refusal test done");
    wr(refbuf_pkg::CAP_OFS, 32'h1);
    pic(32'h200, t);
    rd(refbuf_pkg::IRQS_OFS, 32'h2, 32'h2);
    rd(refbuf_pkg::STAT_OFS, 32'h2, 32'hFF);
    wr(refbuf_pkg::CAP_OFS, 32'h40);
    pic(32'h102, t);
    cmd(32'h1);
    cmd(32'h0);
    settle();
    rd(refbuf_pkg::STAT_OFS, 32'h1, 32'hFF);
    $display("capacity and reset test done");
    pic(32'h402, s0);
    cmd(32'h0500_0004);
    cmd(32'h0002_0105);
    cmd(32'h0);
    settle();
    info(s0, 32'h0002_000A, 32'h0003_0FFF);
    info(t, 32'h0003_2000, 32'h0003_FF00);
    wr(refbuf_pkg::CAP_OFS, 32'h4);
    pic(32'h200, s1);
    info(t, 32'h0003_2000, 32'h0003_FF00);
    info(s1, 32'h0002_0003, 32'h0003_0FFF);
    rd(refbuf_pkg::STAT_OFS, 32'h3, 32'hFF);
    rd(8'hFC, 32'h0, 32'hFFFF_FFFF, refbuf_pkg::RESP_DEC);
    wr(8'hFC, 32'h0, refbuf_pkg::RESP_DEC);
    $display("sub-picture and long-term test done");
    end_of_test();
  end
endmodule : test_reference_picture_buffer_manager
